/* verilog/ast_top.sv */
// Asynchronous serial transceiver with double-buffered transmit and
// receive paths, reached by software over a classic Wishbone slave.
// Assumes the bit clocks and serial input come from pins, asynchronous
// to clk_i, and are slower than a quarter of clk_i.
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "ast_regs.svh"
module ast_top
	import ast_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic tx_clock_in_i,
	input wire logic rx_clock_in_i,
	input wire logic serial_in_i,
	output logic serial_out_o,
	output logic end_of_char_o,
	output logic tx_buffer_empty_o,
	output logic rx_available_flag_o,
	output logic framing_error_flag_o,
	output logic parity_error_o,
	output logic overrun_o,
	output logic [7:0] rx_char_out_o
);

	// Pin synchronisers. Stage one feeds stage two only; the edge
	// detectors compare stages two and three.
	logic [2:0] tx_clk_sync_r;
	logic [2:0] rx_clk_sync_r;
	logic [1:0] rxd_sync_r;
	logic tx_tick;
	logic rx_tick;

	// Bus decode.
	logic bus_req;
	logic bus_wr;
	logic [1:0] reg_idx;
	logic low_lane;

	// Control holding register and its decoded forms.
	ast_cfg_t cfg_r;
	logic [2:0] last_bit;
	logic [5:0] stop_len;
	logic [7:0] len_mask;

	// Transmit side.
	logic [7:0] tx_hold_r;
	ast_state_t tx_state_r;
	logic [7:0] tx_shift_r;
	logic [2:0] tx_bit_r;
	logic [5:0] tx_tick_r;
	logic tx_par_r;
	logic tx_load;
	logic tx_take;

	// Receive side.
	logic rx_done;
	ast_rx_word_t rx_word;
	logic rx_clear;

	// --------------------------------------------------------------
	// Synchronisers and tick generation.
	// --------------------------------------------------------------

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_clk_sync_r <= 3'h0;
		end else begin
			tx_clk_sync_r <= {tx_clk_sync_r[1:0], tx_clock_in_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_clk_sync_r <= 3'h0;
		end else begin
			rx_clk_sync_r <= {rx_clk_sync_r[1:0], rx_clock_in_i};
		end
	end

	// The serial line idles at mark, so the synchroniser resets high
	// to avoid a false start bit after reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxd_sync_r <= 2'h3;
		end else begin
			rxd_sync_r <= {rxd_sync_r[0], serial_in_i};
		end
	end

	assign tx_tick = tx_clk_sync_r[1] && !tx_clk_sync_r[2];
	assign rx_tick = rx_clk_sync_r[1] && !rx_clk_sync_r[2];

	// --------------------------------------------------------------
	// Wishbone slave. Every access is answered one cycle after the
	// request appears; reads ignore the lane selects, unused bits read as zero.
	// --------------------------------------------------------------

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_req && wb_we_i;
	assign reg_idx = wb_adr_i[3:2];
	assign low_lane = wb_sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= 32'h00000000;
			case (reg_idx)
			`AST_OFF_CTRL: begin
				wb_dat_o[4:0] <= cfg_r;
			end
			`AST_OFF_TXDATA: begin
				wb_dat_o[7:0] <= tx_hold_r;
			end
			`AST_OFF_RXDATA: begin
				wb_dat_o[7:0] <= rx_char_out_o;
			end
			`AST_OFF_STATUS: begin
				wb_dat_o[`AST_ST_PARITY_ERR] <= parity_error_o;
				wb_dat_o[`AST_ST_OVERRUN] <= overrun_o;
				wb_dat_o[`AST_ST_TX_EMPTY] <= tx_buffer_empty_o;
				wb_dat_o[`AST_ST_FRAMING_ERR] <= framing_error_flag_o;
				wb_dat_o[`AST_ST_AVAILABLE] <= rx_available_flag_o;
			end
			default: begin
				wb_dat_o <= 32'h00000000;
			end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Control holding register.
	// --------------------------------------------------------------

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r <= `AST_CTRL_RESET;
		end else if (bus_wr && low_lane && reg_idx == `AST_OFF_CTRL) begin
			cfg_r <= wb_dat_i[4:0];
		end
	end

	// Binary length code: 00 gives five bits, 11 gives eight.
	assign last_bit = 3'({cfg_r.length_select_hi, cfg_r.length_select_lo}) +
		3'h4;

	always_comb begin
		len_mask = 8'hFF;
		case ({cfg_r.length_select_hi, cfg_r.length_select_lo})
		2'h0: begin
			len_mask = 8'h1F;
		end
		2'h1: begin
			len_mask = 8'h3F;
		end
		2'h2: begin
			len_mask = 8'h7F;
		end
		default: begin
			len_mask = 8'hFF;
		end
		endcase
	end

	always_comb begin
		stop_len = `AST_STOP_ONE;
		if (cfg_r.two_stop_select) begin
			if ({cfg_r.length_select_hi, cfg_r.length_select_lo} == 2'h0) begin
				stop_len = `AST_STOP_ONE_HALF;
			end else begin
				stop_len = `AST_STOP_TWO;
			end
		end
	end

	// --------------------------------------------------------------
	// Transmit holding register. A write to the data register stands
	// for the strobe's trailing edge. A write while the buffer is full
	// replaces the held character; software should wait for empty.
	// --------------------------------------------------------------

	assign tx_load = bus_wr && low_lane && reg_idx == `AST_OFF_TXDATA;
	assign tx_take = tx_state_r == AST_IDLE && !tx_buffer_empty_o &&
		tx_tick;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_hold_r <= 8'h00;
		end else if (tx_load) begin
			tx_hold_r <= wb_dat_i[7:0] & len_mask;
		end
	end

	// A load in the same cycle as the transfer wins, so the new
	// character is not lost.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_buffer_empty_o <= 1'b1;
		end else if (tx_load) begin
			tx_buffer_empty_o <= 1'b0;
		end else if (tx_take) begin
			tx_buffer_empty_o <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// Transmit shifter.
	// --------------------------------------------------------------

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_r <= AST_IDLE;
			tx_shift_r <= 8'h00;
			tx_bit_r <= 3'h0;
			tx_tick_r <= 6'h00;
			tx_par_r <= 1'b0;
		end else if (tx_tick) begin
			tx_tick_r <= tx_tick_r + 6'h01;
			case (tx_state_r)
			AST_IDLE: begin
				tx_tick_r <= 6'h00;
				if (tx_take) begin
					tx_shift_r <= tx_hold_r;
					tx_par_r <= ^tx_hold_r ^ !cfg_r.parity_even_select;
					tx_state_r <= AST_START;
				end
			end
			AST_START: begin
				if (tx_tick_r == `AST_TICKS_PER_BIT - 6'h01) begin
					tx_tick_r <= 6'h00;
					tx_bit_r <= 3'h0;
					tx_state_r <= AST_DATA;
				end
			end
			AST_DATA: begin
				if (tx_tick_r == `AST_TICKS_PER_BIT - 6'h01) begin
					tx_tick_r <= 6'h00;
					tx_shift_r <= {1'b0, tx_shift_r[7:1]};
					tx_bit_r <= tx_bit_r + 3'h1;
					if (tx_bit_r == last_bit) begin
						tx_state_r <= cfg_r.parity_inhibit ? AST_STOP :
							AST_PARITY;
					end
				end
			end
			AST_PARITY: begin
				if (tx_tick_r == `AST_TICKS_PER_BIT - 6'h01) begin
					tx_tick_r <= 6'h00;
					tx_state_r <= AST_STOP;
				end
			end
			AST_STOP: begin
				if (tx_tick_r == stop_len - 6'h01) begin
					tx_tick_r <= 6'h00;
					tx_state_r <= AST_IDLE;
				end
			end
			default: begin
				tx_state_r <= AST_IDLE;
			end
			endcase
		end
	end

	// Line level follows the state of the shifter; mark is high.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_out_o <= 1'b1;
		end else begin
			case (tx_state_r)
			AST_START: begin
				serial_out_o <= 1'b0;
			end
			AST_DATA: begin
				serial_out_o <= tx_shift_r[0];
			end
			AST_PARITY: begin
				serial_out_o <= tx_par_r;
			end
			default: begin
				serial_out_o <= 1'b1;
			end
			endcase
		end
	end

	// End of character rises one tick, a sixteenth of a bit, before the stop
	// time ends and falls when the next start bit begins.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			end_of_char_o <= 1'b1;
		end else if (tx_tick && tx_state_r == AST_STOP &&
			tx_tick_r == stop_len - 6'h02) begin
			end_of_char_o <= 1'b1;
		end else if (tx_state_r == AST_START) begin
			end_of_char_o <= 1'b0;
		end else if (tx_state_r == AST_IDLE) begin
			end_of_char_o <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// Receive engine and holding registers.
	// --------------------------------------------------------------

	ast_rx u_rx (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rx_tick_i(rx_tick),
		.rxd_i(rxd_sync_r[1]),
		.cfg_i(cfg_r),
		.done_o(rx_done),
		.word_o(rx_word)
	);

	assign rx_clear = bus_wr && low_lane && reg_idx == `AST_OFF_STATUS &&
		wb_dat_i[`AST_ST_AVAILABLE];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_char_out_o <= 8'h00;
			framing_error_flag_o <= 1'b0;
			parity_error_o <= 1'b0;
		end else if (rx_done) begin
			rx_char_out_o <= rx_word.char_val;
			framing_error_flag_o <= rx_word.framing_err;
			parity_error_o <= rx_word.parity_err;
		end
	end

	// A new character arriving in the cycle of a clear keeps the flag
	// set, and only counts as overrun if the old one was never cleared.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_available_flag_o <= 1'b0;
		end else if (rx_done) begin
			rx_available_flag_o <= 1'b1;
		end else if (rx_clear) begin
			rx_available_flag_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overrun_o <= 1'b0;
		end else if (rx_done) begin
			overrun_o <= rx_available_flag_o && !rx_clear;
		end
	end

endmodule : ast_top

/* shared/ast_regs.svh */
// Register offsets, field positions, reset values and timing counts of the
// asynchronous serial transceiver. Included by the package and the design.
// Operation
// - Separate tx and rx clocks at 16x baud
// - Transmitter and receiver run fully independently
// - Five to eight data bits per character
// - Stop select low one, high two stops
// - Five-bit characters use one or 1.5 stops
// - Parity inhibit drops parity bit and check
// - Parity select low odd, high even
// - Control strobe copies format into holding register
// - Buffer empty high when holding register free
// - Data strobe trailing edge loads holding register
// - Short characters use low data bits only
// - Empty shifter takes held character, starts sending
// - End-of-character high 1/16 bit early, idle
// - Serial out mark high, idles high
// - Detect falling edge, verify mid-start, centre sampling
// - Parity error when enabled check fails
// - Framing error when first stop is low
// - Stop sampled: store char, flags, set available
// - Received char right-justified, unused bits low
// - Host clears data-available after reading character
// - Overrun when available still set, held
// - Status word shows errors, empty and available
// - Reset clears registers, sets out, eoc, empty
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

`define AST_OFF_CTRL 2'h0
`define AST_OFF_TXDATA 2'h1
`define AST_OFF_RXDATA 2'h2
`define AST_OFF_STATUS 2'h3

`define AST_CTRL_LEN_LO 0
`define AST_CTRL_LEN_HI 1
`define AST_CTRL_TWO_STOP 2
`define AST_CTRL_PAR_INHIBIT 3
`define AST_CTRL_PAR_EVEN 4

`define AST_ST_PARITY_ERR 0
`define AST_ST_OVERRUN 1
`define AST_ST_TX_EMPTY 2
`define AST_ST_FRAMING_ERR 3
`define AST_ST_AVAILABLE 4

`define AST_CTRL_RESET 5'h00
`define AST_MIN_BITS 4'h5
`define AST_TICKS_PER_BIT 6'h10
`define AST_MID_TICK 4'h7
`define AST_LAST_TICK 4'hF
`define AST_STOP_ONE 6'h10
`define AST_STOP_ONE_HALF 6'h18
`define AST_STOP_TWO 6'h20

`endif

/* shared/ast_pkg.sv */
// Types shared by the transceiver modules.
// Assumes ast_regs.svh sits on the include path.
`include "ast_regs.svh"
package ast_pkg;

	typedef struct packed {
		logic parity_even_select;
		logic parity_inhibit;
		logic two_stop_select;
		logic length_select_hi;
		logic length_select_lo;
	} ast_cfg_t;

	typedef enum logic [2:0] {
		AST_IDLE = 3'h0,
		AST_START = 3'h1,
		AST_DATA = 3'h3,
		AST_PARITY = 3'h2,
		AST_STOP = 3'h6
	} ast_state_t;

	typedef struct packed {
		logic [7:0] char_val;
		logic parity_err;
		logic framing_err;
	} ast_rx_word_t;

endpackage : ast_pkg

/* verilog/ast_rx.sv */
// Receive engine: turns a synchronised serial input into characters.
// Assumes rx_tick_i is a one-cycle pulse at sixteen times the baud rate.
`timescale 1ns/1ps
`include "ast_regs.svh"
module ast_rx
	import ast_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rx_tick_i,
	input wire logic rxd_i,
	input wire ast_cfg_t cfg_i,
	output logic done_o,
	output ast_rx_word_t word_o
);

	ast_state_t state_r;
	logic [3:0] tick_r;
	logic [2:0] bit_r;
	logic [7:0] data_r;
	logic par_r;
	logic prev_r;
	logic [2:0] last_bit;

	assign last_bit = 3'({cfg_i.length_select_hi, cfg_i.length_select_lo}) +
		3'h4;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_r <= 1'b1;
		end else if (rx_tick_i) begin
			prev_r <= rxd_i;
		end
	end

	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		if (rst_i) begin
			state_r <= AST_IDLE;
			tick_r <= 4'h0;
			bit_r <= 3'h0;
			data_r <= 8'h00;
			par_r <= 1'b0;
			word_o <= '0;
		end else if (rx_tick_i) begin
			tick_r <= tick_r + 4'h1;
			case (state_r)
			AST_IDLE: begin
				tick_r <= 4'h0;
				if (prev_r && !rxd_i) begin
					state_r <= AST_START;
				end
			end
			AST_START: begin
				if (tick_r == `AST_MID_TICK) begin
					tick_r <= 4'h0;
					bit_r <= 3'h0;
					data_r <= 8'h00;
					state_r <= rxd_i ? AST_IDLE : AST_DATA;
				end
			end
			AST_DATA: begin
				if (tick_r == `AST_LAST_TICK) begin
					data_r[bit_r] <= rxd_i;
					bit_r <= bit_r + 3'h1;
					if (bit_r == last_bit) begin
						state_r <= cfg_i.parity_inhibit ? AST_STOP :
							AST_PARITY;
					end
				end
			end
			AST_PARITY: begin
				if (tick_r == `AST_LAST_TICK) begin
					par_r <= rxd_i;
					state_r <= AST_STOP;
				end
			end
			AST_STOP: begin
				if (tick_r == `AST_LAST_TICK) begin
					word_o.char_val <= data_r;
					word_o.framing_err <= !rxd_i;
					word_o.parity_err <= !cfg_i.parity_inhibit &&
						((^data_r ^ par_r) ^ !cfg_i.parity_even_select);
					done_o <= 1'b1;
					state_r <= AST_IDLE;
				end
			end
			default: begin
				state_r <= AST_IDLE;
			end
			endcase
		end
	end

endmodule : ast_rx

/* verification/ast_top_asserts.sv */
// Checker for the transceiver's bus port and serial pins.
// Assumes it is bound to ast_top and shares its single clock.
`timescale 1ns/1ps
module ast_top_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic serial_out_o,
	input wire logic end_of_char_o,
	input wire logic tx_buffer_empty_o,
	input wire logic rx_available_flag_o,
	input wire logic framing_error_flag_o,
	input wire logic parity_error_o,
	input wire logic overrun_o,
	input wire logic [7:0] rx_char_out_o
);
	// Reset is released by a write on a clock edge, so the edge after it
	// still sees flags falling from reset. The delayed copy covers that.
	logic rst_seen_r;
	always_ff @(posedge clk_i) begin
		rst_seen_r <= rst_i;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || rst_seen_r);
	logic req;
	logic [4:0] stw;
	assign req = wb_cyc_i && wb_stb_i;
	assign stw = {rx_available_flag_o, framing_error_flag_o,
		tx_buffer_empty_o, overrun_o, parity_error_o};
	sequence start_edge_s;
		$fell(serial_out_o) && $past(end_of_char_o);
	endsequence
	sequence start_low_s;
		!serial_out_o [*8];
	endsequence
	ack_answer_a: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged");
	reset_state_a: assert property (disable iff (1'b0) rst_i |=>
		serial_out_o && end_of_char_o && stw == 5'h04)
		else $error("outputs not at reset state");
	idle_mark_a: assert property (end_of_char_o |-> $past(serial_out_o))
		else $error("line low while end of character high");
	eoc_fall_a: assert property (start_edge_s |-> ##[0:2] !end_of_char_o)
		else $error("end of character kept high into start bit");
	start_hold_a: assert property (start_edge_s |-> start_low_s)
		else $error("start bit cut short");
	load_cause_a: assert property ($fell(tx_buffer_empty_o) |->
		$past(req && wb_we_i && wb_adr_i[3:2] == 2'h1))
		else $error("buffer empty fell without a load");
	shift_start_a: assert property ($rose(tx_buffer_empty_o) |->
		##[0:2] !serial_out_o)
		else $error("buffer freed without a start bit");
	avail_clear_a: assert property ($fell(rx_available_flag_o) |->
		$past(req && wb_we_i && wb_adr_i[3:2] == 2'h3 && wb_dat_i[4]))
		else $error("available cleared without a request");
	char_flag_a: assert property ($changed(rx_char_out_o) |->
		rx_available_flag_o)
		else $error("character loaded without available");
	overrun_set_a: assert property ($rose(overrun_o) |->
		rx_available_flag_o && $past(rx_available_flag_o))
		else $error("overrun raised with no waiting character");
	overrun_drop_a: assert property ($fell(overrun_o) |->
		rx_available_flag_o)
		else $error("overrun dropped without a new character");
	status_read_a: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i[3:2] == 2'h3 && $stable(stw) |-> wb_dat_o[4:0] == stw)
		else $error("status word does not match flags");
endmodule : ast_top_asserts

bind ast_top ast_top_asserts u_asserts (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .serial_out_o(serial_out_o),
	.end_of_char_o(end_of_char_o), .tx_buffer_empty_o(tx_buffer_empty_o),
	.rx_available_flag_o(rx_available_flag_o),
	.framing_error_flag_o(framing_error_flag_o),
	.parity_error_o(parity_error_o), .overrun_o(overrun_o),
	.rx_char_out_o(rx_char_out_o));

/* verification/ast_line_model.sv */
// Far end of the serial line: bit clocks, frame sender and capturer.
// Assumes the bench calls its tasks by hierarchical name.
`timescale 1ns/1ps
module ast_line_model (
	input wire logic serial_out_i,
	input wire logic end_of_char_i,
	output logic serial_in_o,
	output logic tx_clock_o,
	output logic rx_clock_o
);
	// Unequal periods keep the two bit clocks unrelated in phase.
	initial begin
		tx_clock_o = 1'b0;
		forever #30 tx_clock_o = ~tx_clock_o;
	end
	initial begin
		rx_clock_o = 1'b0;
		forever #35 rx_clock_o = ~rx_clock_o;
	end
	initial serial_in_o = 1'b1;
	task automatic send(input logic [11:0] f, input int n);
		@(posedge rx_clock_o);
		for (int i = 0; i < n; i++) begin
			serial_in_o <= f[i];
			repeat (16) @(posedge rx_clock_o);
		end
		serial_in_o <= 1'b1;
	endtask : send
	// Samples mid-bit and counts ticks until end of character rises.
	task automatic capture(output logic [11:0] f, output int t);
		f = 12'h000;
		t = 0;
		@(negedge serial_out_i);
		while (!(end_of_char_i && t > 16) && t < 400) begin
			@(posedge tx_clock_o);
			t++;
			if (t % 16 == 8 && t / 16 < 12)
				f[t / 16] = serial_out_i;
		end
	endtask : capture
endmodule : ast_line_model

/* verification/tb.sv */
// Self-checking bench: bus, both directions at once, error flags,
// overrun, back-to-back sends and reset. Uses ast_line_model.
`timescale 1ns/1ps
module tb;
	import ast_pkg::*;
	typedef struct packed {
		ast_cfg_t cfg;
		logic [7:0] d;
		logic [1:0] k;
		logic [7:0] t;
		logic [1:0] e;
	} ast_row_t;
	// k 1 flips the parity bit when parity is on, k 2 a low stop; t is ticks to end of char.
	localparam ast_row_t ROWS [9] = '{
		'{5'h00, 8'hFF, 2'h0, 8'h80, 2'h0},
		'{5'h11, 8'hA5, 2'h1, 8'h90, 2'h1},
		'{5'h0A, 8'h3C, 2'h1, 8'h90, 2'h0},
		'{5'h17, 8'h81, 2'h0, 8'hC0, 2'h0},
		'{5'h04, 8'h0A, 2'h2, 8'h88, 2'h2},
		'{5'h0F, 8'h5A, 2'h0, 8'hB0, 2'h0},
		'{5'h03, 8'h00, 2'h1, 8'hB0, 2'h1},
		'{5'h1C, 8'hE7, 2'h0, 8'h78, 2'h0},
		'{5'h06, 8'h7F, 2'h2, 8'hB0, 2'h2}};
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic tx_clk, rx_clk, sin, sout, eoc, tx_buffer_empty, avail, fe, pe_o, ov;
	logic [7:0] rx_char;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	ast_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .tx_clock_in_i(tx_clk), .rx_clock_in_i(rx_clk),
		.serial_in_i(sin), .serial_out_o(sout), .end_of_char_o(eoc),
		.tx_buffer_empty_o(tx_buffer_empty), .rx_available_flag_o(avail),
		.framing_error_flag_o(fe), .parity_error_o(pe_o), .overrun_o(ov),
		.rx_char_out_o(rx_char));
	ast_line_model line (.serial_out_i(sout), .end_of_char_i(eoc),
		.serial_in_o(sin), .tx_clock_o(tx_clk), .rx_clock_o(rx_clk));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	always @(posedge clk_i) begin
		cyc++;
		// All scenarios need about 30000 cycles; the ceiling leaves margin.
		if (cyc == 60000) begin
			n_fail++;
			finish_test;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
			n_fail++;
		end
	endtask : check
	task automatic wb_xfer(input logic [3:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// Waits as long as the slave needs; only the cycle ceiling ends a hang.
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb_xfer
	initial begin
		logic [31:0] q;
		logic [11:0] cf, cf2, ftx, frx, m;
		logic [7:0] dm;
		ast_cfg_t c;
		int n, pe, s, t, t2;
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check({sout, eoc, tx_buffer_empty, avail, ov, fe, pe_o}, 7'h70);
		foreach (ROWS[r]) begin
			c = ROWS[r].cfg;
			n = 5 + {c.length_select_hi, c.length_select_lo};
			dm = ROWS[r].d & (8'hFF >> (8 - n));
			pe = !c.parity_inhibit;
			s = n + 1 + pe;
			ftx = 12'hFFF;
			ftx[0] = 1'b0;
			for (int i = 0; i < n; i++)
				ftx[i + 1] = dm[i];
			if (pe)
				ftx[n + 1] = c.parity_even_select ? ^dm : ~^dm;
			frx = ftx;
			if (ROWS[r].k == 2'h1)
				frx[n + 1] = frx[n + 1] ^ pe;
			if (ROWS[r].k == 2'h2)
				frx[s] = 1'b0;
			wb_xfer(4'h0, 1'b1, {27'h0, c}, q);
			wb_xfer(4'h0, 1'b0, 32'h0, q);
			check(q, {27'h0, c});
			// Both directions run at once to show they are independent.
			fork
				line.capture(cf, t);
				wb_xfer(4'h4, 1'b1, {24'h0, ROWS[r].d}, q);
				line.send(frx, s + 1);
			join
			m = (12'h1 << (s + 1)) - 12'h1;
			check(cf & m, ftx & m);
			check(t, ROWS[r].t);
			check({avail, rx_char}, {1'b1, dm});
			wb_xfer(4'hC, 1'b0, 32'h0, q);
			check(q, {27'h0, 1'b1, ROWS[r].e[1], 2'h2, ROWS[r].e[0]});
			wb_xfer(4'h8, 1'b0, 32'h0, q);
			check(q, dm);
			wb_xfer(4'hC, 1'b1, 32'h10, q);
			@(posedge clk_i);
			check(avail, 1'b0);
		end
		// Eight bits, odd parity, one stop for the remaining frames.
		wb_xfer(4'h0, 1'b1, 32'h3, q);
		repeat (2) line.send(12'hF86, 11);
		wb_xfer(4'hF, 1'b0, 32'h0, q);
		check({q, rx_char}, {32'h16, 8'hC3});
		wb_xfer(4'hC, 1'b1, 32'h10, q);
		@(posedge clk_i);
		check({ov, avail}, 2'h2);
		line.send(12'hF86, 11);
		check({ov, avail}, 2'h1);
		fork
			begin
				line.capture(cf, t);
				line.capture(cf2, t2);
			end
			begin
				wb_xfer(4'h4, 1'b1, 32'h55, q);
				repeat (300) begin
					if (tx_buffer_empty !== 1'b1)
						@(posedge clk_i);
				end
				check(tx_buffer_empty, 1'b1);
				wb_xfer(4'h4, 1'b1, 32'hAA, q);
				@(posedge clk_i);
				check(tx_buffer_empty, 1'b0);
			end
		join
		check({cf[10:0], cf2[10:0]}, {11'h6AA, 11'h754});
		check({t[7:0], t2[7:0]}, 16'hB0B0);
		wb_xfer(4'h4, 1'b0, 32'h0, q);
		check(q, 32'hAA);
		wb_xfer(4'h4, 1'b1, 32'h0, q);
		repeat (100) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check({sout, eoc, tx_buffer_empty, avail}, 4'hE);
		finish_test;
	end
endmodule : tb
